// [logic/sad_regs.svh]
// Address map constants and timing counts for the system address decoder
`ifndef SAD_REGS_SVH
`define SAD_REGS_SVH

// Ends of the signed address space and boot entry
`define SAD_MOST_NEGATIVE_ADDRESS 32'h8000_0000
`define SAD_MOST_POSITIVE_ADDRESS 32'h7fff_ffff
`define SAD_BOOT_FETCH_POINT 32'h7fff_fffe
`define SAD_BOOT_JUMP_REACH 32'h0000_0100

// Bank boundaries; bank index is the top two bits with the sign flipped
`define SAD_BANK_FLIP 2'h2
`define SAD_BANK1_BASE 32'hc000_0000
`define SAD_BANK3_BASE 32'h4000_0000

// Memories
`define SAD_SRAM_SIZE 32'h0001_0000
`define SAD_ROM_BASE 32'h7ffe_0000
`define SAD_EXT_RAM_BASE 32'h8100_0000

// Processor-private words below the user area
`define SAD_USER_MEMORY_BASE 32'h8000_0140
`define SAD_TRAP_AREA_BASE 32'h8000_0040
`define SAD_LOW_TRAP_BASE 32'h8000_00c0
`define SAD_LAST_TRAP_STRUCT 32'h8000_0130
`define SAD_DSP_CHANNEL_WORD 32'h8000_0014

// Peripheral region and slot bases
`define SAD_PERIPH_TOP 32'h3fff_ffff
`define SAD_EMI_BASE 32'h0000_2000
`define SAD_DIAG_BASE 32'h0000_3000
`define SAD_LOW_RESERVED_BASE 32'h0000_4000
`define SAD_INTC_BASE 32'h2000_0000
`define SAD_ILC_BASE 32'h2000_1000
`define SAD_RTC_BASE 32'h2000_2000
`define SAD_FIRST_UART_BASE 32'h2000_4000
`define SAD_SECOND_UART_BASE 32'h2000_6000
`define SAD_PIO_A_BASE 32'h2000_8000
`define SAD_PIO_B_BASE 32'h2000_a000
`define SAD_DSP_CTRL_BASE 32'h2000_c000
`define SAD_SLOT_BITS 12

// Pins, opcodes and timing
`define SAD_EXT_ADDR_BITS 20
`define SAD_DEV_OPCODE_BASE 16'h2ff0
`define SAD_DEV_OPCODE_LAST 16'h2ff5
`define SAD_DEV_ACCESS_CYCLES 3
`define SAD_STRAP_SETTLE 2'h2

`endif

// [logic/sad_pkg.sv]
// Types shared by the system address decoder modules
`default_nettype none
package sad_pkg;

   // Where a request is sent
   typedef enum logic [1:0] {sad_tgt_sram, sad_tgt_rom, sad_tgt_ext, sad_tgt_periph} sad_target_t;

   // Peripheral slot selected by a device access
   typedef enum logic [3:0] {
      sad_per_none, sad_per_emi, sad_per_diag, sad_per_intc, sad_per_ilc, sad_per_rtc,
      sad_per_first_uart, sad_per_second_uart, sad_per_pio_a, sad_per_pio_b, sad_per_dsp
   } sad_periph_t;

   // Class of a word in the low system area
   typedef enum logic [1:0] {sad_sys_user, sad_sys_reserved, sad_sys_dsp_chan, sad_sys_trap} sad_sys_t;

   // Device access sequence
   typedef enum logic [1:0] {sad_st_idle, sad_st_dev1, sad_st_dev2, sad_st_dev3} sad_state_t;

endpackage
`default_nettype wire

// [logic/sad_periph_if.sv]
// Interface between the decoder and its peripheral slot decoder
`timescale 1ns/1ns
`default_nettype none
interface sad_periph_if;
   logic [31:0] addr;
   logic hit;
   sad_pkg::sad_periph_t slot;
   logic [11:0] offset;
   modport requester (output addr, input hit, input slot, input offset);
   modport decoder (input addr, output hit, output slot, output offset);
endinterface
`default_nettype wire

// [logic/sad_periph_decode.sv]
// Peripheral slot decoder for device accesses
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.svh"
module sad_periph_decode
(
   sad_periph_if.decoder dec
);

   logic [31:0] block;

   // Slot base is the address with the 4K offset bits cleared
   always_comb
   begin
      block = dec.addr & ~((32'h1 << `SAD_SLOT_BITS) - 32'h1);
      dec.hit = (dec.addr <= `SAD_PERIPH_TOP);
      dec.offset = dec.addr[11:0];
      // Only the first 4K of each base decodes; the rest of the region answers as empty
      case (block)
         `SAD_EMI_BASE: dec.slot = sad_pkg::sad_per_emi;
         `SAD_DIAG_BASE: dec.slot = sad_pkg::sad_per_diag;
         `SAD_INTC_BASE: dec.slot = sad_pkg::sad_per_intc;
         `SAD_ILC_BASE: dec.slot = sad_pkg::sad_per_ilc;
         `SAD_RTC_BASE: dec.slot = sad_pkg::sad_per_rtc;
         `SAD_FIRST_UART_BASE: dec.slot = sad_pkg::sad_per_first_uart;
         `SAD_SECOND_UART_BASE: dec.slot = sad_pkg::sad_per_second_uart;
         `SAD_PIO_A_BASE: dec.slot = sad_pkg::sad_per_pio_a;
         `SAD_PIO_B_BASE: dec.slot = sad_pkg::sad_per_pio_b;
         `SAD_DSP_CTRL_BASE: dec.slot = sad_pkg::sad_per_dsp;
         default: dec.slot = sad_pkg::sad_per_none;
      endcase
   end

endmodule // sad_periph_decode
`default_nettype wire

// [logic/sad_decoder.sv]
// System address decoder: bank, memory, system area and peripheral routing
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.svh"
module sad_decoder
#(
   parameter int EXT_ADDR_BITS = `SAD_EXT_ADDR_BITS
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic rom_programmed_pin,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_addr,
   input wire logic [15:0] req_opcode,
   input wire logic [31:0] req_wdata,
   output logic route_valid,
   output sad_pkg::sad_target_t rt_target,
   output logic [1:0] rt_bank,
   output logic [29:0] rt_word_addr,
   output logic [1:0] rt_byte_sel,
   output logic [EXT_ADDR_BITS-1:0] rt_ext_addr,
   output logic rt_ext_ram,
   output sad_pkg::sad_periph_t rt_periph,
   output logic [11:0] rt_periph_offset,
   output sad_pkg::sad_sys_t rt_sys,
   output logic rt_trap_low,
   output logic [1:0] rt_trap_group,
   output logic rt_trap_trapped,
   output logic periph_sel,
   output logic periph_we,
   output logic [1:0] periph_size,
   output logic [31:0] periph_wdata,
   input wire logic [31:0] periph_rdata,
   output logic resp_valid,
   output logic [31:0] resp_rdata,
   output logic rom_enabled,
   output logic [31:0] boot_fetch_addr,
   output logic [31:0] boot_jump_floor,
   output logic [31:0] user_memory_base
);

   logic take;
   logic dev_op;
   logic dev_write;
   logic [1:0] dev_size;
   logic [31:0] off;
   logic [31:0] trap_off;
   sad_periph_if pif ();

   // Strap capture state
   logic sync1_q, sync1_d, sync2_q, sync2_d;
   logic [1:0] strap_cnt_q, strap_cnt_d;
   logic strap_done_q, strap_done_d;
   logic rom_enabled_q, rom_enabled_d;

   // Route state
   logic route_valid_q, route_valid_d;
   sad_pkg::sad_target_t rt_target_q, rt_target_d;
   logic [1:0] rt_bank_q, rt_bank_d;
   logic [29:0] rt_word_addr_q, rt_word_addr_d;
   logic [1:0] rt_byte_sel_q, rt_byte_sel_d;
   logic [EXT_ADDR_BITS-1:0] rt_ext_addr_q, rt_ext_addr_d;
   logic rt_ext_ram_q, rt_ext_ram_d;
   sad_pkg::sad_periph_t rt_periph_q, rt_periph_d;
   logic [11:0] rt_periph_offset_q, rt_periph_offset_d;
   sad_pkg::sad_sys_t rt_sys_q, rt_sys_d;
   logic rt_trap_low_q, rt_trap_low_d;
   logic [1:0] rt_trap_group_q, rt_trap_group_d;
   logic rt_trap_trapped_q, rt_trap_trapped_d;

   // Device access state
   sad_pkg::sad_state_t state_q, state_d;
   logic dev_write_q, dev_write_d;
   logic periph_sel_q, periph_sel_d;
   logic periph_we_q, periph_we_d;
   logic [1:0] periph_size_q, periph_size_d;
   logic [31:0] periph_wdata_q, periph_wdata_d;
   logic [31:0] rdata_q, rdata_d;

   // Fixed system addresses
   logic [31:0] boot_fetch_q, boot_floor_q, user_base_q;

   // Peripheral slot lookup
   assign pif.addr = req_addr;
   sad_periph_decode u_sad_periph_decode (.dec(pif.decoder));

   // Request decode helpers; device opcodes carry write in bit 0, size in bits 2:1
   assign dev_op = (req_opcode >= `SAD_DEV_OPCODE_BASE) && (req_opcode <= `SAD_DEV_OPCODE_LAST);
   assign dev_write = req_opcode[0];
   assign dev_size = req_opcode[2:1];
   assign off = req_addr ^ `SAD_MOST_NEGATIVE_ADDRESS;
   assign trap_off = off - (`SAD_TRAP_AREA_BASE ^ `SAD_MOST_NEGATIVE_ADDRESS);
   assign take = req_valid && req_ready;

   // No request until the ROM strap is known and no device access is running
   assign req_ready = (state_q == sad_pkg::sad_st_idle) && strap_done_q;

   // ROM strap: pin is synchronised, then caught once after reset release
   always_comb
   begin
      sync1_d = rom_programmed_pin;
      sync2_d = sync1_q;
      strap_cnt_d = strap_cnt_q;
      strap_done_d = strap_done_q;
      rom_enabled_d = rom_enabled_q;
      if (!strap_done_q)
      begin
         if (strap_cnt_q == `SAD_STRAP_SETTLE)
         begin
            rom_enabled_d = sync2_q;
            strap_done_d = 1'b1;
         end
         else
         begin
            strap_cnt_d = strap_cnt_q + 2'h1;
         end
      end
   end

   // Strap registers; ROM counts as disabled until caught
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         strap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
         rom_enabled_q <= 1'b0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         strap_cnt_q <= strap_cnt_d;
         strap_done_q <= strap_done_d;
         rom_enabled_q <= rom_enabled_d;
      end
   end

   // Route decision for each taken request; fields hold until the next one
   always_comb
   begin
      route_valid_d = take;
      rt_target_d = rt_target_q;
      rt_bank_d = rt_bank_q;
      rt_word_addr_d = rt_word_addr_q;
      rt_byte_sel_d = rt_byte_sel_q;
      rt_ext_addr_d = rt_ext_addr_q;
      rt_ext_ram_d = rt_ext_ram_q;
      rt_periph_d = rt_periph_q;
      rt_periph_offset_d = rt_periph_offset_q;
      rt_sys_d = rt_sys_q;
      rt_trap_low_d = rt_trap_low_q;
      rt_trap_group_d = rt_trap_group_q;
      rt_trap_trapped_d = rt_trap_trapped_q;
      dev_write_d = dev_write_q;
      if (take)
      begin
         rt_bank_d = req_addr[31:30] ^ `SAD_BANK_FLIP;
         rt_word_addr_d = req_addr[31:2];
         rt_byte_sel_d = req_addr[1:0];
         // Upper bits dropped: memory aliases every 1 Mbyte in each bank
         rt_ext_addr_d = req_addr[EXT_ADDR_BITS-1:0];
         rt_ext_ram_d = (req_addr[31:30] == 2'h2) && (req_addr >= `SAD_EXT_RAM_BASE);
         rt_periph_d = pif.slot;
         rt_periph_offset_d = pif.offset;
         dev_write_d = dev_write;
         // Device opcode decides the peripheral path; ordinary accesses never take it
         if (dev_op && pif.hit)
            rt_target_d = sad_pkg::sad_tgt_periph;
         else if (off < `SAD_SRAM_SIZE)
            rt_target_d = sad_pkg::sad_tgt_sram;
         else if (!req_addr[31] && (req_addr >= `SAD_ROM_BASE) && rom_enabled_q)
            rt_target_d = sad_pkg::sad_tgt_rom;
         else
            rt_target_d = sad_pkg::sad_tgt_ext;
         // Classify the processor-private words below the user base
         rt_trap_low_d = 1'b0;
         rt_trap_group_d = 2'h0;
         rt_trap_trapped_d = 1'b0;
         if (off >= (`SAD_USER_MEMORY_BASE ^ `SAD_MOST_NEGATIVE_ADDRESS))
            rt_sys_d = sad_pkg::sad_sys_user;
         else if (off >= (`SAD_TRAP_AREA_BASE ^ `SAD_MOST_NEGATIVE_ADDRESS))
         begin
            rt_sys_d = sad_pkg::sad_sys_trap;
            rt_trap_low_d = trap_off[7];
            rt_trap_group_d = trap_off[6:5];
            rt_trap_trapped_d = trap_off[4];
         end
         else if ((req_addr & 32'hffff_fffc) == `SAD_DSP_CHANNEL_WORD)
            rt_sys_d = sad_pkg::sad_sys_dsp_chan;
         else
            rt_sys_d = sad_pkg::sad_sys_reserved;
      end
   end

   // Route registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         route_valid_q <= 1'b0;
         rt_target_q <= sad_pkg::sad_tgt_ext;
         rt_bank_q <= 2'h0;
         rt_word_addr_q <= 30'h0;
         rt_byte_sel_q <= 2'h0;
         rt_ext_addr_q <= '0;
         rt_ext_ram_q <= 1'b0;
         rt_periph_q <= sad_pkg::sad_per_none;
         rt_periph_offset_q <= 12'h0;
         rt_sys_q <= sad_pkg::sad_sys_user;
         rt_trap_low_q <= 1'b0;
         rt_trap_group_q <= 2'h0;
         rt_trap_trapped_q <= 1'b0;
         dev_write_q <= 1'b0;
      end
      else
      begin
         route_valid_q <= route_valid_d;
         rt_target_q <= rt_target_d;
         rt_bank_q <= rt_bank_d;
         rt_word_addr_q <= rt_word_addr_d;
         rt_byte_sel_q <= rt_byte_sel_d;
         rt_ext_addr_q <= rt_ext_addr_d;
         rt_ext_ram_q <= rt_ext_ram_d;
         rt_periph_q <= rt_periph_d;
         rt_periph_offset_q <= rt_periph_offset_d;
         rt_sys_q <= rt_sys_d;
         rt_trap_low_q <= rt_trap_low_d;
         rt_trap_group_q <= rt_trap_group_d;
         rt_trap_trapped_q <= rt_trap_trapped_d;
         dev_write_q <= dev_write_d;
      end
   end

   // Device access: strobe in cycle 1, data in cycle 2, answer in cycle 3
   always_comb
   begin
      state_d = state_q;
      periph_sel_d = 1'b0;
      periph_we_d = 1'b0;
      periph_size_d = periph_size_q;
      periph_wdata_d = periph_wdata_q;
      rdata_d = rdata_q;
      unique case (state_q)
         sad_pkg::sad_st_idle:
         begin
            if (take && dev_op && pif.hit)
            begin
               state_d = sad_pkg::sad_st_dev1;
               // Empty slot sees no strobe, so a write there has no effect
               periph_sel_d = (pif.slot != sad_pkg::sad_per_none);
               periph_we_d = dev_write && (pif.slot != sad_pkg::sad_per_none);
               periph_size_d = dev_size;
               periph_wdata_d = req_wdata;
            end
         end
         sad_pkg::sad_st_dev1:
            state_d = sad_pkg::sad_st_dev2;
         sad_pkg::sad_st_dev2:
         begin
            state_d = sad_pkg::sad_st_dev3;
            if (dev_write_q || (rt_periph_q == sad_pkg::sad_per_none))
               rdata_d = 32'h0;
            else if (periph_size_q == 2'h0)
               rdata_d = {24'h0, periph_rdata[7:0]};
            else if (periph_size_q == 2'h1)
               rdata_d = {16'h0, periph_rdata[15:0]};
            else
               rdata_d = periph_rdata;
         end
         sad_pkg::sad_st_dev3:
            state_d = sad_pkg::sad_st_idle;
      endcase
   end

   // Device access registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= sad_pkg::sad_st_idle;
         periph_sel_q <= 1'b0;
         periph_we_q <= 1'b0;
         periph_size_q <= 2'h0;
         periph_wdata_q <= 32'h0;
         rdata_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         periph_sel_q <= periph_sel_d;
         periph_we_q <= periph_we_d;
         periph_size_q <= periph_size_d;
         periph_wdata_q <= periph_wdata_d;
         rdata_q <= rdata_d;
      end
   end

   // Fixed addresses for boot and for the user-base query
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         boot_fetch_q <= `SAD_BOOT_FETCH_POINT;
         boot_floor_q <= `SAD_BOOT_FETCH_POINT - `SAD_BOOT_JUMP_REACH;
         user_base_q <= `SAD_USER_MEMORY_BASE;
      end
      else
      begin
         boot_fetch_q <= boot_fetch_q;
         boot_floor_q <= boot_floor_q;
         user_base_q <= user_base_q;
      end
   end

   // Outputs
   assign route_valid = route_valid_q;
   assign rt_target = rt_target_q;
   assign rt_bank = rt_bank_q;
   assign rt_word_addr = rt_word_addr_q;
   assign rt_byte_sel = rt_byte_sel_q;
   assign rt_ext_addr = rt_ext_addr_q;
   assign rt_ext_ram = rt_ext_ram_q;
   assign rt_periph = rt_periph_q;
   assign rt_periph_offset = rt_periph_offset_q;
   assign rt_sys = rt_sys_q;
   assign rt_trap_low = rt_trap_low_q;
   assign rt_trap_group = rt_trap_group_q;
   assign rt_trap_trapped = rt_trap_trapped_q;
   assign periph_sel = periph_sel_q;
   assign periph_we = periph_we_q;
   assign periph_size = periph_size_q;
   assign periph_wdata = periph_wdata_q;
   assign resp_valid = (state_q == sad_pkg::sad_st_dev3);
   assign resp_rdata = rdata_q;
   assign rom_enabled = rom_enabled_q;
   assign boot_fetch_addr = boot_fetch_q;
   assign boot_jump_floor = boot_floor_q;
   assign user_memory_base = user_base_q;

   // Checks on the routing decisions and device accesses
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_word_split: assert property (take |=> {rt_word_addr, rt_byte_sel} == $past(req_addr))
      else $error("word address and byte selector do not match request");
   a_bank_edges: assert property (take |=> rt_bank == ($past(req_addr[31]) ?
      ($past(req_addr) >= `SAD_BANK1_BASE ? 2'h1 : 2'h0) : ($past(req_addr) >= `SAD_BANK3_BASE ? 2'h3 : 2'h2)))
      else $error("bank does not follow boundaries");
   a_pins_low_only: assert property (route_valid |-> rt_ext_addr == {rt_word_addr[17:0], rt_byte_sel})
      else $error("external address carries wrong bits");
   a_sram_window: assert property (take && !dev_op && (req_addr[31:16] == 16'h8000)
      |=> rt_target == sad_pkg::sad_tgt_sram)
      else $error("low 64K not routed to SRAM");
   a_rom_window: assert property (take && !dev_op && !req_addr[31] && req_addr >= `SAD_ROM_BASE
      |=> rt_target == (rom_enabled ? sad_pkg::sad_tgt_rom : sad_pkg::sad_tgt_ext))
      else $error("ROM window misrouted");
   a_periph_path: assert property (take && req_addr[31:30] == 2'h0
      |=> (rt_target == sad_pkg::sad_tgt_periph) == $past(dev_op))
      else $error("peripheral path taken by wrong access kind");
   a_dev_three: assert property (take && dev_op && pif.hit
      |=> !req_ready [*2] ##1 (resp_valid && !req_ready) ##1 (req_ready && !resp_valid))
      else $error("device access not three cycles");
   a_empty_slot: assert property (resp_valid && rt_periph == sad_pkg::sad_per_none
      |-> resp_rdata == 32'h0 && !$past(periph_we, 2) && !$past(periph_sel, 2))
      else $error("empty slot had an effect");
   a_trap_order: assert property (take && req_addr >= `SAD_LOW_TRAP_BASE && req_addr <= `SAD_LAST_TRAP_STRUCT
      |=> rt_sys == sad_pkg::sad_sys_trap && rt_trap_low)
      else $error("low priority trap area misclassified");

endmodule // sad_decoder
`default_nettype wire

// [tb/sad_periph_model.sv]
// Behavioural peripheral that answers device accesses from the decoder
`timescale 1ns/1ns
`default_nettype none
module sad_periph_model
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic periph_sel,
   input wire logic periph_we,
   input wire logic [31:0] periph_wdata,
   output var logic [31:0] periph_rdata
);
   logic [31:0] store_q;

   // One register; data only valid the cycle after a read select, toggles otherwise
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         store_q <= 32'h0;
         periph_rdata <= 32'h5a5a_5a5a;
      end
      else
      begin
         if (periph_sel && periph_we)
            store_q <= periph_wdata;
         periph_rdata <= (periph_sel && !periph_we) ? store_q : ~periph_rdata;
      end
   end
endmodule // sad_periph_model
`default_nettype wire

// [tb/system_address_decoder_bench.sv]
// Self-checking bench for the system address decoder
`timescale 1ns/1ns
`default_nettype none
module system_address_decoder_bench;
   logic sys_clk, rst, rom_programmed_pin, req_valid, req_ready, route_valid, rt_ext_ram, rt_trap_low;
   logic rt_trap_trapped, periph_sel, periph_we, resp_valid, rom_enabled;
   logic [31:0] req_addr, req_wdata, periph_wdata, periph_rdata, resp_rdata;
   logic [31:0] boot_fetch_addr, boot_jump_floor, user_memory_base;
   logic [15:0] req_opcode;
   logic [1:0] rt_bank, rt_byte_sel, rt_trap_group, periph_size;
   logic [29:0] rt_word_addr;
   logic [19:0] rt_ext_addr;
   logic [11:0] rt_periph_offset;
   sad_pkg::sad_target_t rt_target;
   sad_pkg::sad_periph_t rt_periph;
   sad_pkg::sad_sys_t rt_sys;
   int errors = 0;
   int check_count = 0;

   sad_decoder u_sad_decoder (.sys_clk, .rst, .rom_programmed_pin, .req_valid, .req_ready, .req_addr,
      .req_opcode, .req_wdata, .route_valid, .rt_target, .rt_bank, .rt_word_addr, .rt_byte_sel,
      .rt_ext_addr, .rt_ext_ram, .rt_periph, .rt_periph_offset, .rt_sys, .rt_trap_low, .rt_trap_group,
      .rt_trap_trapped, .periph_sel, .periph_we, .periph_size, .periph_wdata, .periph_rdata,
      .resp_valid, .resp_rdata, .rom_enabled, .boot_fetch_addr, .boot_jump_floor, .user_memory_base);
   sad_periph_model u_sad_periph_model (.sys_clk, .rst, .periph_sel, .periph_we, .periph_wdata,
      .periph_rdata);

   // 20 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic test_done;
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Offer one request; ordinary ones keep valid up so the next can follow back to back
   task automatic go(input logic [31:0] a, input logic [15:0] op, input logic [31:0] wd);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 20)
      begin
         @(posedge sys_clk);
         #5;
         n++;
      end
      req_addr = a;
      req_opcode = op;
      req_wdata = wd;
      req_valid = 1'b1;
      @(posedge sys_clk);
      #5;
      if (op[15:4] == 12'h2ff)
         req_valid = 1'b0;
      chk("route_valid", 32'h1, route_valid);
   endtask

   task automatic route(input logic [31:0] a, input logic [15:0] op, input logic [31:0] tgt,
                        input logic [31:0] bank, input logic [31:0] xr);
      go(a, op, 32'h0);
      chk("target", tgt, rt_target);
      chk("bank", bank, rt_bank);
      chk("ext_ram", xr, rt_ext_ram);
      chk("word", a[31:2], rt_word_addr);
      chk("byte", a[1:0], rt_byte_sel);
      chk("ext_addr", a[19:0], rt_ext_addr);
   endtask

   task automatic sys(input logic [31:0] a, input logic [31:0] cls, input logic [31:0] low,
                      input logic [31:0] grp, input logic [31:0] trp);
      go(a, 16'h00f1, 32'h0);
      chk("sys", cls, rt_sys);
      chk("trap_low", low, rt_trap_low);
      chk("trap_group", grp, rt_trap_group);
      chk("trapped", trp, rt_trap_trapped);
   endtask

   // Device access: strobe in the cycle after take, answer two edges later
   task automatic dev(input logic [31:0] a, input logic [15:0] op, input logic [31:0] wd,
                      input logic [31:0] slot, input logic [31:0] rd);
      int n;
      go(a, op, wd);
      chk("target", sad_pkg::sad_tgt_periph, rt_target);
      chk("slot", slot, rt_periph);
      chk("offset", a[11:0], rt_periph_offset);
      chk("sel", slot != sad_pkg::sad_per_none, periph_sel);
      if (periph_sel === 1'b1)
      begin
         chk("we", op[0], periph_we);
         chk("size", op[2:1], periph_size);
         if (op[0])
            chk("wdata", wd, periph_wdata);
      end
      n = 0;
      while (resp_valid !== 1'b1 && n < 6)
      begin
         @(posedge sys_clk);
         #5;
         n++;
      end
      chk("resp_delay", 32'h2, n);
      chk("rdata", rd, resp_rdata);
   endtask

   task automatic do_reset(input logic strap);
      rst = 1'b1;
      rom_programmed_pin = strap;
      req_valid = 1'b0;
      repeat (4) @(posedge sys_clk);
      #5;
      chk("ready_in_reset", 32'h0, req_ready);
      rst = 1'b0;
   endtask

   // Main sequence
   initial
   begin
      logic [31:0] base [9];
      sad_pkg::sad_periph_t pid [9];
      base = '{32'h2000, 32'h3000, 32'h2000_0000, 32'h2000_1000, 32'h2000_2000, 32'h2000_6000,
               32'h2000_8000, 32'h2000_a000, 32'h2000_c000};
      pid = '{sad_pkg::sad_per_emi, sad_pkg::sad_per_diag, sad_pkg::sad_per_intc, sad_pkg::sad_per_ilc,
              sad_pkg::sad_per_rtc, sad_pkg::sad_per_second_uart, sad_pkg::sad_per_pio_a,
              sad_pkg::sad_per_pio_b, sad_pkg::sad_per_dsp};
      req_addr = 32'h0;
      req_opcode = 16'h0;
      req_wdata = 32'h0;
      do_reset(1'b1);
      route(32'h8000_0000, 16'h00f1, sad_pkg::sad_tgt_sram, 0, 0);
      route(32'h8000_ffff, 16'h00f1, sad_pkg::sad_tgt_sram, 0, 0);
      route(32'h8001_0000, 16'h00f1, sad_pkg::sad_tgt_ext, 0, 0);
      route(32'h8100_0002, 16'h00f1, sad_pkg::sad_tgt_ext, 0, 1);
      route(32'hc000_0001, 16'h00f1, sad_pkg::sad_tgt_ext, 1, 0);
      route(32'h3ff5_a5a7, 16'h00f1, sad_pkg::sad_tgt_ext, 2, 0);
      route(32'h4000_0000, 16'h2ff4, sad_pkg::sad_tgt_ext, 3, 0);
      route(32'h7ffd_fffc, 16'h00f1, sad_pkg::sad_tgt_ext, 3, 0);
      route(32'h7ffe_0000, 16'h00f1, sad_pkg::sad_tgt_rom, 3, 0);
      route(32'h8000_0300, 16'h2ff0, sad_pkg::sad_tgt_sram, 0, 0);
      chk("rom_enabled", 32'h1, rom_enabled);
      chk("boot_fetch", 32'h7fff_fffe, boot_fetch_addr);
      chk("jump_floor", 32'h7fff_fefe, boot_jump_floor);
      chk("user_base", 32'h8000_0140, user_memory_base);
      sys(32'h8000_0014, sad_pkg::sad_sys_dsp_chan, 0, 0, 0);
      sys(32'h8000_0018, sad_pkg::sad_sys_reserved, 0, 0, 0);
      sys(32'h8000_0040, sad_pkg::sad_sys_trap, 0, 0, 0);
      sys(32'h8000_00b0, sad_pkg::sad_sys_trap, 0, 3, 1);
      sys(32'h8000_00c0, sad_pkg::sad_sys_trap, 1, 0, 0);
      sys(32'h8000_00f0, sad_pkg::sad_sys_trap, 1, 1, 1);
      sys(32'h8000_0130, sad_pkg::sad_sys_trap, 1, 3, 1);
      sys(32'h8000_0140, sad_pkg::sad_sys_user, 0, 0, 0);
      dev(32'h2000_4010, 16'h2ff1, 32'h1111_2233, sad_pkg::sad_per_first_uart, 0);
      dev(32'h2000_4012, 16'h2ff3, 32'h4455_6677, sad_pkg::sad_per_first_uart, 0);
      dev(32'h2000_4014, 16'h2ff5, 32'ha5c3_1e77, sad_pkg::sad_per_first_uart, 0);
      dev(32'h2000_4010, 16'h2ff0, 32'h0, sad_pkg::sad_per_first_uart, 32'h77);
      dev(32'h2000_4012, 16'h2ff2, 32'h0, sad_pkg::sad_per_first_uart, 32'h1e77);
      for (int i = 0; i < 9; i++)
         dev(base[i] + 32'hffc, 16'h2ff4, 32'h0, pid[i], 32'ha5c3_1e77);
      dev(32'h0000_4000, 16'h2ff4, 32'h0, sad_pkg::sad_per_none, 32'h0);
      dev(32'h2000_3000, 16'h2ff4, 32'h0, sad_pkg::sad_per_none, 32'h0);
      dev(32'h2000_e000, 16'h2ff5, 32'h1234_5678, sad_pkg::sad_per_none, 32'h0);
      dev(32'h2000_4000, 16'h2ff4, 32'h0, sad_pkg::sad_per_first_uart, 32'ha5c3_1e77);
      dev(32'h0000_0ff0, 16'h2ff4, 32'h0, sad_pkg::sad_per_none, 32'h0);
      @(posedge sys_clk);
      #5;
      do_reset(1'b0);
      route(32'h7fff_fffe, 16'h00f1, sad_pkg::sad_tgt_ext, 3, 0);
      chk("rom_enabled", 32'h0, rom_enabled);
      test_done;
   end

   // Watchdog well beyond the hundred or so cycles the sequence needs
   initial
   begin
      #400000;
      errors++;
      test_done;
   end
endmodule // system_address_decoder_bench
`default_nettype wire
